// file: bench/pbtc_assertions.sv
// Concurrent checks on the timer/counter top-level ports
`timescale 1ns/1ns
`default_nettype none
module pbtc_assertions
   import pbtc_pkg::*;
(
   // Clock, reset, enable
   input wire logic                   CLOCK_IN,
   input wire logic                   RST_B_IN,
   input wire logic                   CLK_EN_IN,
   // Control and straps
   input wire logic                   START_PULSE_IN,
   input wire logic                   RESET_PULSE_IN,
   input wire logic                   CONTINUOUS_MODE_IN,
   input wire logic                   SYNTH_MODE_IN,
   input wire logic                   INT_TIMEBASE_EN_IN,
   input wire logic [TB_PERIOD_W-1:0] TB_PERIOD_IN,
   input wire logic                   EXT_CLOCK_IN,
   input wire logic                   COUNT_INHIBIT_IN,
   input wire logic [CNT_W-1:0]       BUS_SELECT_IN,
   // Watched outputs
   input wire logic [CNT_W-1:0]       WEIGHTED_COUNT_OUTPUTS_OUT,
   input wire logic [CNT_W-1:0]       COUNT_VALUE_OUT,
   input wire logic                   BUS_OUT,
   input wire logic                   TIMEBASE_PULSE_NODE_OUT,
   input wire logic                   RUNNING_OUT
);
   // ------------------------------------------------------------
   // Single domain, so one clock and one disable for all
   // ------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_B_IN);

   idle_outs_high_a: assert property (!RUNNING_OUT |-> WEIGHTED_COUNT_OUTPUTS_OUT == 8'hFF && COUNT_VALUE_OUT == 8'h00)
      else $error("idle outputs not released");
   reset_stops_a: assert property (CLK_EN_IN && RESET_PULSE_IN |=> !RUNNING_OUT)
      else $error("reset pulse did not stop the cycle");
   start_clear_a: assert property (CLK_EN_IN && START_PULSE_IN && !RESET_PULSE_IN && !RUNNING_OUT
      |=> RUNNING_OUT && WEIGHTED_COUNT_OUTPUTS_OUT == 8'h00)
      else $error("start did not clear the count");
   start_ignore_a: assert property (CLK_EN_IN && START_PULSE_IN && !RESET_PULSE_IN && RUNNING_OUT && !SYNTH_MODE_IN
      && COUNT_VALUE_OUT != 8'hFF && COUNT_VALUE_OUT != 8'h00 |=> RUNNING_OUT && COUNT_VALUE_OUT != 8'h00)
      else $error("start while running took effect");
   outs_word_a: assert property (RUNNING_OUT |-> WEIGHTED_COUNT_OUTPUTS_OUT == COUNT_VALUE_OUT)
      else $error("outputs differ from count word");
   bus_wired_a: assert property ($past(CLK_EN_IN)
      |-> BUS_OUT == &($past(WEIGHTED_COUNT_OUTPUTS_OUT) | ~$past(BUS_SELECT_IN)))
      else $error("bus level not the wired-OR");
   clamp_hold_a: assert property (COUNT_INHIBIT_IN && !RESET_PULSE_IN && !START_PULSE_IN |=> $stable(COUNT_VALUE_OUT))
      else $error("count moved under clamp");
   ext_step_a: assert property (CLK_EN_IN && !INT_TIMEBASE_EN_IN && !COUNT_INHIBIT_IN && !RESET_PULSE_IN && RUNNING_OUT
      && !SYNTH_MODE_IN && TIMEBASE_PULSE_NODE_OUT && !EXT_CLOCK_IN |=> COUNT_VALUE_OUT == $past(COUNT_VALUE_OUT) + 8'h01)
      else $error("external falling edge did not step count");
   idle_node_high_a: assert property (CLK_EN_IN && !RUNNING_OUT && INT_TIMEBASE_EN_IN && !COUNT_INHIBIT_IN
      |=> TIMEBASE_PULSE_NODE_OUT)
      else $error("time base runs in idle");
endmodule
bind pbtc_top pbtc_assertions u_chk (.*);
`default_nettype wire

// file: bench/pbtc_pulse_src.sv
// Model of the trigger, reset and external clock sources
`timescale 1ns/1ns
`default_nettype none
module pbtc_pulse_src (
   // Clock
   input  wire logic clk_in,
   // Pulses towards the counter
   output var logic  start_out,
   output var logic  reset_out,
   output var logic  ext_clk_out
);
   // Quiet sources at time zero
   initial begin
      start_out = 1'b0;
      reset_out = 1'b0;
      ext_clk_out = 1'b0;
   end
   // One-cycle positive pulse, launched off the sampling edge
   task automatic pulse(input logic s, input logic r);
      @(negedge clk_in);
      start_out = s;
      reset_out = r;
      @(negedge clk_in);
      start_out = 1'b0;
      reset_out = 1'b0;
   endtask
   // Each phase ten cycles, so never shorter than 1 us
   task automatic ext_edges(input int n);
      repeat (n) begin
         @(negedge clk_in);
         ext_clk_out = 1'b1;
         repeat (10) @(negedge clk_in);
         ext_clk_out = 1'b0;
         repeat (9) @(negedge clk_in);
      end
   endtask
endmodule
`default_nettype wire

// file: bench/tb_programmable_binary_timer_counter.sv
// Self-checking bench for the binary timer/counter
`timescale 1ns/1ns
`default_nettype none
module tb_programmable_binary_timer_counter
   import pbtc_pkg::*;
;
   // Above the shortest period, so the programmed period really matters
   localparam int P = 12;
   logic       clk, rst_b, clk_en, cont, synth, int_en, inhibit, bus, node, running;
   logic [15:0] period;
   logic [7:0] sel, outs, count;
   wire        start, rst_p, ext;
   int         fail_count, cmp_count;

   // ------------------------------------------------------------
   // Design and pulse sources
   // ------------------------------------------------------------
   pbtc_pulse_src u_src (.clk_in(clk), .start_out(start), .reset_out(rst_p), .ext_clk_out(ext));
   pbtc_top u_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(clk_en), .START_PULSE_IN(start),
      .RESET_PULSE_IN(rst_p), .CONTINUOUS_MODE_IN(cont), .SYNTH_MODE_IN(synth), .INT_TIMEBASE_EN_IN(int_en),
      .TB_PERIOD_IN(period), .EXT_CLOCK_IN(ext), .COUNT_INHIBIT_IN(inhibit), .BUS_SELECT_IN(sel),
      .WEIGHTED_COUNT_OUTPUTS_OUT(outs), .COUNT_VALUE_OUT(count), .BUS_OUT(bus),
      .TIMEBASE_PULSE_NODE_OUT(node), .RUNNING_OUT(running));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compare tasks: values, then cycle counts
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bounded wait on the bus level or the count
   task automatic wait_for(input bit on_bus, input logic [7:0] v, output int n);
      n = 0;
      while ((on_bus ? {7'h00, bus} : count) !== v) begin
         @(negedge clk);
         n++;
         if (n > 5000) begin
            fail_count++;
            print_verdict();
         end
      end
   endtask
   // Idle state after power-on reset
   task automatic t_reset();
      chk(outs, 8'hFF);
      chk(count, 8'h00);
      chk({6'h00, bus, node}, 8'h03);
      chk({7'h00, running}, 8'h00);
      $display("test reset done");
   endtask
   // External clock: start, count, clamp, ignored start, reset
   task automatic t_ext();
      int_en = 1'b0;
      u_src.pulse(1'b1, 1'b0);
      u_src.ext_edges(3);
      chk(count, 8'h03);
      chk(outs, 8'h03);
      inhibit = 1'b1;
      u_src.ext_edges(2);
      inhibit = 1'b0;
      repeat (2) @(negedge clk);
      chk(count, 8'h03);
      u_src.pulse(1'b1, 1'b0);
      @(negedge clk);
      chk({7'h00, running}, 8'h01);
      chk(count, 8'h03);
      u_src.pulse(1'b0, 1'b1);
      @(negedge clk);
      chk({7'h00, running}, 8'h00);
      chk(outs, 8'hFF);
      u_src.pulse(1'b1, 1'b1);
      @(negedge clk);
      chk({7'h00, running}, 8'h00);
      $display("test external clock done");
   endtask
   // Bus pulse width and repeat period under the internal time base
   task automatic t_pattern(input logic [7:0] s, input logic sy, input int wexp, input int pexp);
      int a, b;
      int_en = 1'b1;
      sel = s;
      synth = sy;
      u_src.pulse(1'b0, 1'b1);
      u_src.pulse(1'b1, 1'b0);
      wait_for(1, 8'h00, a);
      wait_for(1, 8'h01, a);
      wait_for(1, 8'h00, a);
      wait_for(1, 8'h01, b);
      chk_n(a, wexp);
      chk_n(a + b, pexp);
      $display("test pattern done");
   endtask
   // Full cycle of 256 states then wrap
   task automatic t_wrap();
      int a, b;
      wait_for(0, 8'h02, a);
      wait_for(0, 8'h03, a);
      wait_for(0, 8'h02, b);
      chk_n(a + b, 256 * P);
      $display("test wrap done");
   endtask
   // Self-start after power-up in continuous mode
   task automatic t_cont();
      cont = 1'b1;
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      chk(outs, 8'hFF);
      rst_b = 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk({7'h00, running}, 8'h01);
      $display("test continuous done");
   endtask

   // Main sequence
   initial begin
      {rst_b, cont, synth, inhibit} = 4'h0;
      clk_en = 1'b1;
      int_en = 1'b1;
      period = 16'(P);
      sel = 8'h00;
      fail_count = 0;
      cmp_count = 0;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      t_reset();
      t_ext();
      t_pattern(8'h30, 1'b0, 16 * P, 64 * P);
      t_wrap();
      t_pattern(8'h0D, 1'b1, P, 14 * P);
      t_cont();
      print_verdict();
   end
endmodule
`default_nettype wire

// file: hdl/pbtc_bus.sv
// Wired-OR combiner of the selected weighted count outputs
`timescale 1ns/1ns
`default_nettype none
module pbtc_bus
   import pbtc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             clk_en_in,
   // Outputs and selection
   input  wire logic [CNT_W-1:0] outs_in,
   input  wire logic [CNT_W-1:0] sel_in,
   // Combined level
   output logic                  level_out,
   output logic                  bus_out
);

   logic bus_q;
   logic bus_d;

   // ------------------------------------------------------------
   // Combined level, registered copy for the pin
   // ------------------------------------------------------------
   always_comb begin
      level_out = pbtc_bus_level(outs_in, sel_in);
      bus_d     = level_out;
   end

   // Unselected outputs float and read as the pull-up level
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bus_q <= 1'b1;
      end else if (clk_en_in) begin
         bus_q <= bus_d;
      end
   end

   assign bus_out = bus_q;

endmodule
`default_nettype wire

// file: hdl/pbtc_pkg.sv
// Shared constants, types and decode helpers for the binary timer/counter
`default_nettype none
package pbtc_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int CNT_W       = 8;
   localparam int TB_PERIOD_W = 16;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   // Least width of the low phase of the time-base pulse
   localparam int TB_LOW_NS     = 500;
   localparam int TB_LOW_CYC    = (TB_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Shortest period accepted, so that a high phase always exists
   localparam logic [TB_PERIOD_W-1:0] TB_PERIOD_MIN = 16'(2 * TB_LOW_CYC);
   localparam logic [TB_PERIOD_W-1:0] TB_LOW_LEN    = 16'(TB_LOW_CYC);

   // ------------------------------------------------------------
   // Reset and start values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0]       OUTS_IDLE_VAL  = 8'hFF;
   localparam logic [CNT_W-1:0]       COUNT_CLR_VAL  = 8'h00;
   localparam logic [CNT_W-1:0]       COUNT_ONE      = 8'h01;
   localparam logic [CNT_W-1:0]       SEL_NONE       = 8'h00;
   localparam logic [TB_PERIOD_W-1:0] DIV_CLR_VAL    = 16'h0000;
   localparam logic [TB_PERIOD_W-1:0] DIV_ONE        = 16'h0001;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {
      PBTC_IDLE,
      PBTC_RUN
   } pbtc_state_t;

   // Wired-OR bus level: low while any selected output is low
   function automatic logic pbtc_bus_level(input logic [CNT_W-1:0] outs,
                                           input logic [CNT_W-1:0] sel);
      pbtc_bus_level = &(outs | ~sel);
   endfunction

endpackage
`default_nettype wire

// file: hdl/pbtc_tick_if.sv
// Interface between the counter control and the time-base node logic
`timescale 1ns/1ns
`default_nettype none
interface pbtc_tick_if;
   import pbtc_pkg::*;

   logic                   run;
   logic                   int_en;
   logic                   inhibit;
   logic                   ext_clk;
   logic [TB_PERIOD_W-1:0] period;
   logic                   tick;
   logic                   node;

   modport ctl (output run, output int_en, output inhibit, output ext_clk, output period,
                input tick, input node);
   modport tb  (input run, input int_en, input inhibit, input ext_clk, input period,
                output tick, output node);
endinterface
`default_nettype wire

// file: hdl/pbtc_timebase.sv
// Time-base node: internal pulse train or external clock, clamp and edge detect
`timescale 1ns/1ns
`default_nettype none
module pbtc_timebase
   import pbtc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic clk_en_in,
   // Node side
   pbtc_tick_if.tb   tb_if
);

   logic [TB_PERIOD_W-1:0] div_q;
   logic [TB_PERIOD_W-1:0] div_d;
   logic                   node_q;
   logic                   node_d;
   logic [TB_PERIOD_W-1:0] eff_period;
   logic                   src;

   // ------------------------------------------------------------
   // Internal oscillator and node level
   // ------------------------------------------------------------
   // Oscillator only runs while a timing cycle is active; reset stops it
   always_comb begin
      eff_period = (tb_if.period < TB_PERIOD_MIN) ? TB_PERIOD_MIN : tb_if.period;
      div_d      = DIV_CLR_VAL;
      src        = 1'b1;
      if (tb_if.int_en) begin
         if (tb_if.run) begin
            div_d = (div_q >= eff_period - DIV_ONE) ? DIV_CLR_VAL : div_q + DIV_ONE;
            // Low phase closes each period, so first fall is about T minus the low phase after start
            src   = (div_q < eff_period - TB_LOW_LEN);
         end
      end else begin
         src = tb_if.ext_clk; // External clock drives the node directly
      end
      node_d = tb_if.inhibit ? 1'b0 : src; // Clamp pulls the node low
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_q  <= DIV_CLR_VAL;
         node_q <= 1'b1;
      end else if (clk_en_in) begin
         div_q  <= div_d;
         node_q <= node_d;
      end
   end

   // ------------------------------------------------------------
   // Count strobe on the falling node edge
   // ------------------------------------------------------------
   // A clamp edge itself must never count, hence the inhibit term
   assign tb_if.tick = clk_en_in & tb_if.run & node_q & ~node_d & ~tb_if.inhibit;
   assign tb_if.node = node_q;

endmodule
`default_nettype wire

// file: hdl/pbtc_top.sv
// Eight-bit programmable binary timer/counter, top level
`timescale 1ns/1ns
`default_nettype none
module pbtc_top
   import pbtc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RST_B_IN,
   input  wire logic                   CLK_EN_IN,
   // Control pulses
   input  wire logic                   START_PULSE_IN,
   input  wire logic                   RESET_PULSE_IN,
   // Mode straps
   input  wire logic                   CONTINUOUS_MODE_IN,
   input  wire logic                   SYNTH_MODE_IN,
   input  wire logic                   INT_TIMEBASE_EN_IN,
   // Time base
   input  wire logic [TB_PERIOD_W-1:0] TB_PERIOD_IN,
   input  wire logic                   EXT_CLOCK_IN,
   input  wire logic                   COUNT_INHIBIT_IN,
   // Output bus selection
   input  wire logic [CNT_W-1:0]       BUS_SELECT_IN,
   // Counter outputs
   output logic [CNT_W-1:0]            WEIGHTED_COUNT_OUTPUTS_OUT,
   output logic [CNT_W-1:0]            COUNT_VALUE_OUT,
   output logic                        BUS_OUT,
   output logic                        TIMEBASE_PULSE_NODE_OUT,
   output logic                        RUNNING_OUT
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   pbtc_tick_if tick_if ();

   pbtc_state_t      state_q;
   pbtc_state_t      state_d;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic [CNT_W-1:0] outs_q;
   logic [CNT_W-1:0] outs_d;
   logic             auto_q;
   logic             auto_d;
   logic             start_req;
   logic             at_modulus;
   logic             bus_level;

   // ------------------------------------------------------------
   // Time-base connection
   // ------------------------------------------------------------
   // Mode inputs are assumed synchronous to CLOCK_IN
   assign tick_if.run     = (state_q == PBTC_RUN);
   assign tick_if.int_en  = INT_TIMEBASE_EN_IN;
   assign tick_if.inhibit = COUNT_INHIBIT_IN;
   assign tick_if.ext_clk = EXT_CLOCK_IN;
   assign tick_if.period  = TB_PERIOD_IN;

   pbtc_timebase u_timebase (
      .clk_in    (CLOCK_IN),
      .rst_b_in  (RST_B_IN),
      .clk_en_in (CLK_EN_IN),
      .tb_if     (tick_if.tb)
   );

   // ------------------------------------------------------------
   // Output bus
   // ------------------------------------------------------------
   pbtc_bus u_bus (
      .clk_in    (CLOCK_IN),
      .rst_b_in  (RST_B_IN),
      .clk_en_in (CLK_EN_IN),
      .outs_in   (outs_q),
      .sel_in    (BUS_SELECT_IN),
      .level_out (bus_level),
      .bus_out   (BUS_OUT)
   );

   // ------------------------------------------------------------
   // Power-up self-start
   // ------------------------------------------------------------
   // One-shot flag set by reset, so the strap is sampled after release
   always_comb begin
      auto_d = auto_q;
      if (CLK_EN_IN) begin
         auto_d = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         auto_q <= 1'b1;
      end else begin
         auto_q <= auto_d;
      end
   end

   // Start request from the pin or from the power-up flag
   assign start_req = START_PULSE_IN | (auto_q & CONTINUOUS_MODE_IN);

   // Synthesizer end point: bus first goes high when count equals N
   // Counts below N always miss at least one selected weight
   assign at_modulus = SYNTH_MODE_IN & bus_level & (BUS_SELECT_IN != SEL_NONE);

   // ------------------------------------------------------------
   // Counter and control state
   // ------------------------------------------------------------
   // All state changes on count strobes, control pulses or the power-up flag only
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      outs_d  = outs_q;
      if (RESET_PULSE_IN) begin
         // Reset wins over a start in the same cycle
         state_d = PBTC_IDLE;
         count_d = COUNT_CLR_VAL;
         outs_d  = OUTS_IDLE_VAL;
      end else begin
         case (state_q)
            PBTC_IDLE: begin
               if (start_req) begin
                  state_d = PBTC_RUN;
                  count_d = COUNT_CLR_VAL;
                  outs_d  = COUNT_CLR_VAL;
               end
            end
            PBTC_RUN: begin
               // Further starts fall through unnoticed here
               if (tick_if.tick) begin
                  if (at_modulus) begin
                     // Retrigger: states 0..N give a period of N+1
                     count_d = COUNT_CLR_VAL;
                  end else begin
                     // Natural 8-bit wrap after 256 states
                     count_d = count_q + COUNT_ONE;
                  end
                  outs_d = count_d;
               end
            end
            default: begin
               state_d = PBTC_IDLE;
               count_d = COUNT_CLR_VAL;
               outs_d  = OUTS_IDLE_VAL;
            end
         endcase
      end
   end

   // Clock enable freezes everything, including pulse detection
   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state_q <= PBTC_IDLE;
         count_q <= COUNT_CLR_VAL;
         outs_q  <= OUTS_IDLE_VAL;
      end else if (CLK_EN_IN) begin
         state_q <= state_d;
         count_q <= count_d;
         outs_q  <= outs_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Open-collector levels: 1 is released, 0 is sinking
   assign WEIGHTED_COUNT_OUTPUTS_OUT = outs_q;
   assign COUNT_VALUE_OUT            = count_q;
   assign TIMEBASE_PULSE_NODE_OUT    = tick_if.node;
   assign RUNNING_OUT                = (state_q == PBTC_RUN);

endmodule
`default_nettype wire
